// ==== mcsc_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef MCSC_MAP_SVH
`define MCSC_MAP_SVH

// ==========================================================
// Register map
`define MCSC_MAIN2_OFS      8'h02
`define MCSC_MAIN2_RESET    8'h00
`define MCSC_BIT_PSAVE      7
`define MCSC_BIT_RESET      6
`define MCSC_BIT_SYNC       4
`define MCSC_BIT_SINGLE_SHOT_ENABLE       3
`define MCSC_BIT_TRIG       2
`define MCSC_MAIN2_MASK     8'hDC

// ==========================================================
// Timing counts in internal clock cycles
`define MCSC_RST_CYCLES     4'h4
`define MCSC_INT_HOLD       3'h6

// ==========================================================
// Sample gap counts per code
`define MCSC_GAP_C0         22'h00_0000
`define MCSC_GAP_C1         22'h00_0F9E
`define MCSC_GAP_C2         22'h00_1F3B
`define MCSC_GAP_C3         22'h00_3E76
`define MCSC_GAP_C4         22'h00_7CEC
`define MCSC_GAP_C5         22'h00_F9D8
`define MCSC_GAP_C6         22'h01_F3B0
`define MCSC_GAP_C7         22'h03_E760
`define MCSC_GAP_C8         22'h07_CEC0
`define MCSC_GAP_C9         22'h0F_9D80
`define MCSC_GAP_C10        22'h1F_3B00
`define MCSC_GAP_CMAX       22'h3E_7600

`endif

// ==== mcsc_pkg.sv ====
// Types shared by the control block and its gap timer
package mcsc_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    MCSC_IDLE,
    MCSC_CONV,
    MCSC_GAP,
    MCSC_RESET
  } mcsc_seq_t;

  // ==========================================================
  // Register access request from the serial interface core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcsc_reg_req_t;

  // ==========================================================
  // Conversion cycle commands
  typedef struct packed {
    logic start;
    logic abort;
  } mcsc_conv_ctl_t;

  // ==========================================================
  // Gap timer state
  typedef struct packed {
    logic        fired;
    logic        expired;
    logic [21:0] cnt;
  } mcsc_gap_t;

  // ==========================================================
  // Control block state
  typedef struct packed {
    logic           power_save;
    logic           reset_bit;
    logic           sync_bit;
    logic           single_shot_enable;
    logic           trig;
    logic           sync_prev;
    logic           trig_prev;
    mcsc_seq_t      seq;
    logic [3:0]     rst_cnt;
    logic           soft_rst;
    mcsc_conv_ctl_t conv;
    logic           done_flag;
    logic           pwr_flag;
    logic           irq_n;
    logic [2:0]     irq_cnt;
    logic           results_valid;
    logic [7:0]     rdata;
  } mcsc_state_t;

endpackage : mcsc_pkg

// ==== mcsc_gap_timer.sv ====
// Inter-sample delay timer with code decode
`include "mcsc_map.svh"

module mcsc_gap_timer #(
  parameter int GAP_SHIFT = 0
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [3:0] code,
  output logic            expired
);

  mcsc_pkg::mcsc_gap_t st;
  mcsc_pkg::mcsc_gap_t next_st;

  // ==========================================================
  // Code decode
  function automatic logic [21:0] gap_decode(input logic [3:0] c);
    case (c)
      4'h0:    gap_decode = `MCSC_GAP_C0;
      4'h1:    gap_decode = `MCSC_GAP_C1;
      4'h2:    gap_decode = `MCSC_GAP_C2;
      4'h3:    gap_decode = `MCSC_GAP_C3;
      4'h4:    gap_decode = `MCSC_GAP_C4;
      4'h5:    gap_decode = `MCSC_GAP_C5;
      4'h6:    gap_decode = `MCSC_GAP_C6;
      4'h7:    gap_decode = `MCSC_GAP_C7;
      4'h8:    gap_decode = `MCSC_GAP_C8;
      4'h9:    gap_decode = `MCSC_GAP_C9;
      4'hA:    gap_decode = `MCSC_GAP_C10;
      default: gap_decode = `MCSC_GAP_CMAX;
    endcase
  endfunction : gap_decode

  // ==========================================================
  // Count down while running, one pulse at zero
  always_comb begin
    next_st         = st;
    next_st.expired = 1'b0;
    if (!run) begin
      next_st.fired = 1'b0;
      next_st.cnt   = gap_decode(code) >> GAP_SHIFT;
    end else if (st.cnt != 22'h00_0000) begin
      next_st.cnt = st.cnt - 22'h00_0001;
    end else if (!st.fired) begin
      next_st.fired   = 1'b1;
      next_st.expired = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.expired;

endmodule : mcsc_gap_timer

// ==== mcsc_ctrl.sv ====
// Second main configuration register with power-save, reset, sync and one-shot control
`include "mcsc_map.svh"

module mcsc_ctrl #(
  parameter int GAP_SHIFT = 0
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire mcsc_pkg::mcsc_reg_req_t  reg_req,
  output logic [7:0]                    reg_rdata,
  input  wire logic                     sif_tick,
  input  wire logic                     status_read,
  input  wire logic [3:0]               sample_gap_delay,
  input  wire logic                     eoc_irq_en,
  input  wire logic                     conv_done,
  output mcsc_pkg::mcsc_conv_ctl_t      conv_ctl,
  output logic                          soft_rst,
  output logic                          power_save_ctl,
  output logic                          results_valid,
  output logic                          conversion_done_flag,
  output logic                          powerup_interrupt,
  output logic                          int_n
);

  mcsc_pkg::mcsc_state_t st;
  mcsc_pkg::mcsc_state_t next_st;
  logic                  gap_expired;
  logic                  wr_main;
  logic                  sync_rise;
  logic                  trig_rise;

  // ==========================================================
  // Reset values
  function automatic mcsc_pkg::mcsc_state_t reset_state();
    mcsc_pkg::mcsc_state_t s;
    s               = '0;
    s.seq           = mcsc_pkg::MCSC_IDLE;
    s.irq_n         = 1'b1;
    s.power_save    = 1'(`MCSC_MAIN2_RESET >> `MCSC_BIT_PSAVE);
    return s;
  endfunction : reset_state

  // ==========================================================
  // Gap timer
  mcsc_gap_timer #(
    .GAP_SHIFT (GAP_SHIFT)
  ) u_gap (
    .clk     (clk),
    .resetn  (resetn),
    .run     (st.seq == mcsc_pkg::MCSC_GAP),
    .code    (sample_gap_delay),
    .expired (gap_expired)
  );

  assign wr_main   = reg_req.wr && (reg_req.addr == `MCSC_MAIN2_OFS);
  assign sync_rise = st.sync_bit && !st.sync_prev;
  assign trig_rise = st.trig && !st.trig_prev;

  // ==========================================================
  // Next state
  always_comb begin
    next_st           = st;
    next_st.conv      = '0;
    next_st.sync_prev = st.sync_bit;
    next_st.trig_prev = st.trig;

    // Sync and trigger bits drop on the interface clock after being set
    if (sif_tick) begin
      next_st.sync_bit = 1'b0;
      next_st.trig     = 1'b0;
    end

    // Interrupt pin release after hold time or status read
    if (!st.irq_n) begin
      next_st.irq_cnt = st.irq_cnt - 3'h1;
      if (st.irq_cnt == 3'h1) begin
        next_st.irq_n = 1'b1;
      end
    end
    if (status_read) begin
      next_st.done_flag = 1'b0;
      next_st.pwr_flag  = 1'b0;
      next_st.irq_n     = 1'b1;
    end

    // Register write, unused bits dropped
    if (wr_main && st.seq != mcsc_pkg::MCSC_RESET) begin
      next_st.power_save = reg_req.wdata[`MCSC_BIT_PSAVE];
      next_st.single_shot_enable       = reg_req.wdata[`MCSC_BIT_SINGLE_SHOT_ENABLE];
      if (reg_req.wdata[`MCSC_BIT_SYNC]) begin
        next_st.sync_bit = 1'b1;
      end
      if (reg_req.wdata[`MCSC_BIT_TRIG]) begin
        next_st.trig = 1'b1;
      end
      if (reg_req.wdata[`MCSC_BIT_PSAVE] && !st.power_save) begin
        next_st.done_flag     = 1'b0;
        next_st.pwr_flag      = 1'b0;
        next_st.irq_n         = 1'b1;
        next_st.results_valid = 1'b0;
      end
      if (reg_req.wdata[`MCSC_BIT_RESET]) begin
        next_st.reset_bit  = 1'b1;
        next_st.soft_rst   = 1'b1;
        next_st.rst_cnt    = `MCSC_RST_CYCLES;
        next_st.seq        = mcsc_pkg::MCSC_RESET;
        next_st.conv.abort = (st.seq == mcsc_pkg::MCSC_CONV);
      end
    end

    // End of conversion event, set wins over status read
    // Entering power-save in the same cycle drops the event
    if (conv_done && st.seq == mcsc_pkg::MCSC_CONV && !st.power_save
        && !next_st.power_save) begin
      next_st.results_valid = 1'b1;
      if (eoc_irq_en) begin
        next_st.done_flag = 1'b1;
        next_st.irq_n     = 1'b0;
        next_st.irq_cnt   = `MCSC_INT_HOLD;
      end
    end

    case (st.seq)
      mcsc_pkg::MCSC_RESET: begin
        next_st.rst_cnt = st.rst_cnt - 4'h1;
        if (st.rst_cnt == 4'h1) begin
          next_st          = reset_state();
          next_st.pwr_flag = 1'b1;
          next_st.irq_n    = 1'b0;
          next_st.irq_cnt  = `MCSC_INT_HOLD;
        end
      end
      mcsc_pkg::MCSC_IDLE: begin
        if (!st.power_save && !next_st.power_save && next_st.seq != mcsc_pkg::MCSC_RESET) begin
          if (st.single_shot_enable ? trig_rise : 1'b1) begin
            next_st.conv.start = 1'b1;
            next_st.seq        = mcsc_pkg::MCSC_CONV;
          end
        end
      end
      mcsc_pkg::MCSC_CONV: begin
        if (conv_done && next_st.seq == mcsc_pkg::MCSC_CONV) begin
          next_st.seq = st.single_shot_enable ? mcsc_pkg::MCSC_IDLE : mcsc_pkg::MCSC_GAP;
        end
      end
      mcsc_pkg::MCSC_GAP: begin
        if (st.single_shot_enable) begin
          next_st.seq = mcsc_pkg::MCSC_IDLE;
        end else if (gap_expired && next_st.seq == mcsc_pkg::MCSC_GAP) begin
          next_st.conv.start = 1'b1;
          next_st.seq        = mcsc_pkg::MCSC_CONV;
        end
      end
      default: begin
        next_st.seq = mcsc_pkg::MCSC_IDLE;
      end
    endcase

    // Sync restarts the cycle from any running state
    if (sync_rise && !st.power_save && next_st.seq != mcsc_pkg::MCSC_RESET) begin
      next_st.conv.abort = (st.seq == mcsc_pkg::MCSC_CONV);
      next_st.conv.start = 1'b1;
      next_st.seq        = mcsc_pkg::MCSC_CONV;
    end

    // Power-save stops the sequencer
    // A reset requested in the same write still runs to its end
    if (next_st.power_save && next_st.seq != mcsc_pkg::MCSC_RESET) begin
      next_st.conv.start = 1'b0;
      next_st.conv.abort = (st.seq == mcsc_pkg::MCSC_CONV);
      next_st.seq        = mcsc_pkg::MCSC_IDLE;
    end

    // Read data, unused bits zero
    next_st.rdata = 8'h00;
    if (reg_req.rd && reg_req.addr == `MCSC_MAIN2_OFS) begin
      next_st.rdata = {st.power_save, st.reset_bit, 1'b0, st.sync_bit,
                       st.single_shot_enable, st.trig, 2'b00} & `MCSC_MAIN2_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= reset_state();
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata            = st.rdata;
  assign conv_ctl             = st.conv;
  assign soft_rst             = st.soft_rst;
  assign power_save_ctl       = st.power_save;
  assign results_valid        = st.results_valid;
  assign conversion_done_flag = st.done_flag;
  assign powerup_interrupt    = st.pwr_flag;
  assign int_n                = st.irq_n;

endmodule : mcsc_ctrl

// ==== mcsc_ctrl_sva.sv ====
// Assertion checker for the main control register block
module mcsc_ctrl_sva (
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire mcsc_pkg::mcsc_reg_req_t  reg_req,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     status_read,
  input wire logic                     eoc_irq_en,
  input wire logic                     conv_done,
  input wire mcsc_pkg::mcsc_conv_ctl_t conv_ctl,
  input wire logic                     soft_rst,
  input wire logic                     power_save_ctl,
  input wire logic                     results_valid,
  input wire logic                     conversion_done_flag,
  input wire logic                     powerup_interrupt,
  input wire logic                     int_n
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rst_run;
    soft_rst [*4] ##1 !soft_rst;
  endsequence
  sequence s_int_hold;
    $fell(int_n) ##1 (!status_read && !power_save_ctl) [*5];
  endsequence
  // ==========================================================
  // Properties
  chk_rst_len: assert property (
    $rose(soft_rst) |-> s_rst_run) else $error("soft reset length wrong");
  chk_pwr_after: assert property (
    $fell(soft_rst) |-> ##[0:1] (powerup_interrupt && !int_n)) else $error("no power-up irq");
  chk_unused_zero: assert property (
    reg_rdata[5] == 1'b0 && reg_rdata[1:0] == 2'b00) else $error("unused bits read 1");
  chk_psave_idle: assert property (
    power_save_ctl && $past(power_save_ctl) |-> !conv_ctl.start) else $error("start in psave");
  chk_psave_clr: assert property (
    $rose(power_save_ctl) |-> int_n && !conversion_done_flag && !powerup_interrupt
    && !results_valid) else $error("psave did not clear");
  chk_flag_clr: assert property (
    $fell(conversion_done_flag) |-> $past(status_read) || power_save_ctl || $past(soft_rst))
    else $error("flag lost");
  chk_eoc_raise: assert property (
    conv_done && eoc_irq_en && !power_save_ctl && !soft_rst
    && !(reg_req.wr && reg_req.addr == 8'h02 && reg_req.wdata[7])
    |=> conversion_done_flag && !int_n)
    else $error("eoc irq missing");
  chk_int_hold: assert property (
    s_int_hold |-> !int_n) else $error("int released early");
  chk_int_rel: assert property (
    $fell(int_n) |-> ##6 int_n) else $error("int not released");
  chk_sync_start: assert property (
    reg_req.wr && reg_req.addr == 8'h02 && reg_req.wdata[4] && reg_req.wdata[7:6] == 2'b00
    && !soft_rst && !power_save_ctl |-> ##2 conv_ctl.start) else $error("sync no start");
endmodule : mcsc_ctrl_sva

bind mcsc_ctrl mcsc_ctrl_sva mcsc_ctrl_sva_i (.clk(clk), .resetn(resetn), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .status_read(status_read), .eoc_irq_en(eoc_irq_en),
  .conv_done(conv_done), .conv_ctl(conv_ctl), .soft_rst(soft_rst),
  .power_save_ctl(power_save_ctl), .results_valid(results_valid),
  .conversion_done_flag(conversion_done_flag), .powerup_interrupt(powerup_interrupt),
  .int_n(int_n));

// ==== mcsc_conv_model.sv ====
// Conversion datapath model that ends each started cycle after a random delay unless kill or a new start comes first
module mcsc_conv_model (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire mcsc_pkg::mcsc_conv_ctl_t conv_ctl,
  input  wire logic                     kill,
  output logic                          conv_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  logic done_q;
  // A completion landing while a restart stands belongs to the aborted cycle
  assign conv_done = done_q && !conv_ctl.start;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt == 1) && !kill;
      if (kill) cnt <= 0;
      else if (conv_ctl.start) cnt <= $urandom_range(20, 8);
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : mcsc_conv_model

// ==== mcsc_ctrl_tb.sv ====
// Testbench for the main control register block
module mcsc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     clk = 1'b0;
  logic                     resetn = 1'b0;
  mcsc_pkg::mcsc_reg_req_t  reg_req = '0;
  logic                     sif_tick = 1'b0;
  logic                     status_read = 1'b0;
  logic [3:0]               sample_gap_delay = 4'h1;
  logic                     eoc_irq_en = 1'b1;
  logic [7:0]               reg_rdata;
  logic                     conv_done, soft_rst, power_save_ctl, results_valid;
  logic                     conversion_done_flag, powerup_interrupt, int_n;
  mcsc_pkg::mcsc_conv_ctl_t conv_ctl;
  int                       miscompares = 0, samples_checked = 0, starts = 0, cycles = 0;
  always #4 clk = ~clk;
  mcsc_ctrl #(.GAP_SHIFT(8)) mcsc_ctrl_i (.clk(clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sif_tick(sif_tick), .status_read(status_read),
    .sample_gap_delay(sample_gap_delay), .eoc_irq_en(eoc_irq_en), .conv_done(conv_done),
    .conv_ctl(conv_ctl), .soft_rst(soft_rst), .power_save_ctl(power_save_ctl),
    .results_valid(results_valid), .conversion_done_flag(conversion_done_flag),
    .powerup_interrupt(powerup_interrupt), .int_n(int_n));
  mcsc_conv_model mcsc_conv_model_i (.clk(clk), .resetn(resetn), .conv_ctl(conv_ctl),
    .kill(soft_rst | power_save_ctl), .conv_done(conv_done));
  // ==========================================================
  // Tasks
  task automatic test_done();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (conv_ctl.start) starts <= starts + 1;
    if (cycles == 6000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk(nm, {7'h00, exp}, {7'h00, got});
  endtask : chk_bit
  task automatic wr(input logic [7:0] d);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h02, wdata: d};
    step(1);
    reg_req <= '0;
    step(1);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    chk("reg_rdata", exp, reg_rdata);
    reg_req <= '0;
    step(1);
  endtask : rd_chk
  task automatic tick();
    sif_tick <= 1'b1;
    step(1);
    sif_tick <= 1'b0;
  endtask : tick
  task automatic wait_done();
    int n = 0;
    while (conv_done !== 1'b1 && n < 60) begin
      step(1);
      n++;
    end
    step(1);
  endtask : wait_done
  // ==========================================================
  // Scenarios
  initial begin
    int s0;
    void'($urandom(92));
    step(10);
    resetn <= 1'b1;
    sample_gap_delay <= 4'($urandom_range(2, 1));
    rd_chk(8'h02, 8'h00);
    wr(8'($urandom) & 8'h23);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h05, 8'h00);
    s0 = starts;
    step(300);
    chk_bit("repeat", 1'b1, (starts - s0) >= 2);
    wr(8'h08);
    step(60);
    s0 = starts;
    step(150);
    chk_bit("one_shot_idle", 1'b1, starts == s0);
    status_read <= 1'b1;
    step(1);
    status_read <= 1'b0;
    wr(8'h0C);
    rd_chk(8'h02, 8'h0C);
    tick();
    rd_chk(8'h02, 8'h08);
    wait_done();
    chk_bit("done_flag", 1'b1, conversion_done_flag);
    chk_bit("int_low", 1'b0, int_n);
    step(6);
    chk_bit("int_release", 1'b1, int_n);
    chk_bit("one_start", 1'b1, starts == s0 + 1);
    wr(8'h00);
    s0 = starts;
    step(300);
    chk_bit("resume", 1'b1, (starts - s0) >= 2);
    repeat (3) begin
      s0 = starts;
      wr(8'h10);
      rd_chk(8'h02, 8'h10);
      tick();
      rd_chk(8'h02, 8'h00);
      chk_bit("sync_start", 1'b1, starts > s0);
      step($urandom_range(60, 5));
    end
    wait_done();
    wr(8'h80);
    chk_bit("psave_int", 1'b1, int_n);
    chk_bit("psave_flag", 1'b0, conversion_done_flag);
    s0 = starts;
    step(100);
    chk_bit("psave_idle", 1'b1, starts == s0);
    rd_chk(8'h02, 8'h80);
    chk_bit("results_stale", 1'b0, results_valid);
    wr(8'h00);
    wait_done();
    chk_bit("results_valid", 1'b1, results_valid);
    step(8);
    wr(8'h48);
    step(8);
    chk_bit("pwr_int", 1'b1, powerup_interrupt);
    rd_chk(8'h02, 8'h00);
    test_done();
  end
endmodule : mcsc_ctrl_tb
